// file: src/swt_pkg.sv
package swt_pkg;
  // register offsets, byte addresses of aligned words
  localparam logic [7:0] PORTA_OFF = 8'h00;
  localparam logic [7:0] CFG1_OFF = 8'h04;
  localparam logic [7:0] CFG2_OFF = 8'h08;
  localparam logic [7:0] KBEN_OFF = 8'h0C;
  localparam logic [7:0] KBSC_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] MASK_OFF = 8'h18;
  localparam logic [7:0] MODE_OFF = 8'h1C;
  // field positions
  localparam int LATCH_BIT = 6;
  localparam int PERSEL_BIT = 7;
  localparam int TRIP_BIT = 3;
  localparam int OSCRUN_BIT = 1;
  localparam int WIE_BIT = 6;
  localparam int KMASK_BIT = 1;
  localparam int KACK_BIT = 2;
  localparam int STOP_BIT = 0;
  localparam int WAIT_BIT = 1;
  localparam int PORB_BIT = 2;
  // status bits
  localparam int EV_WAKE = 0;
  localparam int EV_WDOG = 1;
  // reset values
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [5:0] PORTA_RST = 6'h00;
  // periods in cycles of the counting clock
  localparam int WAKE_SHORT = 512;
  localparam int WAKE_LONG = 16384;
  localparam int WDOG_SHORT = 8176;
  localparam int WDOG_LONG = 262128;
  localparam int CNT_W = 18;
endpackage

// file: src/swt_period_counter.sv
`timescale 1ns/1ps
// free counter with a terminal pulse, cleared on demand
module swt_period_counter #(
  parameter int W = 18
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [W-1:0] period_i,
  // result
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } swt_cnt_t;
  swt_cnt_t s_q, s_d;

  // count ticks; done pulses on the last tick of the period
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (clr_i)
      s_d.cnt = '0;
    else if (tick_i)
    begin
      if (s_q.cnt == period_i - W'(1))
      begin
        s_d.cnt = '0;
        s_d.done = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done_o = s_q.done;
endmodule // swt_period_counter

// file: src/swt_wakeup_timer.sv
`timescale 1ns/1ps
// Functional notes
// R1: in stop mode the timer raises a periodic wakeup request without external signals.
// R2: the wakeup interrupt has its own enable but shares the keyboard vector and mask.
// R3: the timer counts the internal rc clock, or the doubled bus clock as an option.
// R4: in wait mode the timer does not count and requests nothing.
// R5: with the wake enable set the timer starts by itself on entering stop mode.
// R6: a wakeup request leaves stop only while the keyboard mask is clear.
// R7: counters restart from zero each time stop mode is entered.
// R8: port a data bit six reads the wakeup latch, 1 pending and 0 not.
// R9: bit six has no pin, direction or pullup behind it.
// R10: osc run in stop keeps the clock source running in stop, else it stops.
// R11: in stop the period select gives 512 cycles when 1 and 16384 when 0.
// R12: outside stop the period select gives 8176 or 262128 quad bus clock cycles.
// R13: config one clears on power-on; other resets keep the trip bit and clear the rest.
// R14: with osc run in stop the doubled bus clock runs in stop and can drive the timer.
// R15: at the period end the latch sets and asks for a keyboard interrupt if allowed.
// R16: the latch clears on keyboard interrupt acknowledge and stays clear with enable 0.
module swt_wakeup_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // clock ticks, each one clk wide
  input wire logic rc_tick_i,
  input wire logic bus2x_tick_i,
  input wire logic bus4x_tick_i,
  // chip status
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  input wire logic por_i,
  input wire logic kbd_ack_i,
  // events
  output logic kbd_irq_o,
  output logic wake_stop_o,
  output logic osc_run_o,
  output logic wdog_reset_o,
  output logic irq_o
);
  typedef struct packed {
    // software visible registers
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [5:0] porta;
    logic wie;
    logic kmask;
    logic use_bus;
    // wakeup request and stop edge detect
    logic latch;
    logic stop_d1;
    // event status and its mask
    logic [1:0] stat;
    logic [1:0] mask;
    // bus answer
    logic ack;
    logic [31:0] rdata;
    // registered outputs
    logic kirq;
    logic wstop;
    logic oscrun;
    logic wdrst;
    logic irq;
  } swt_state_t;
  swt_state_t s_q, s_d;

  // counter results and derived strobes
  logic wake_done;
  logic wdog_done;
  logic stop_entry;
  logic wake_tick;
  logic wdog_tick;
  // bus decode
  logic wr;
  logic rd;
  // counter restarts
  logic wake_clr;
  logic wdog_clr;
  // selected periods, in ticks of each counting clock
  logic [swt_pkg::CNT_W-1:0] wake_per;
  logic [swt_pkg::CNT_W-1:0] wdog_per;

  // period choice, shared by both counters
  // int constants are cut to the counter width on purpose
  function automatic logic [swt_pkg::CNT_W-1:0] pick(input logic sel, input int s,
                                                     input int l);
    pick = sel ? swt_pkg::CNT_W'(s) : swt_pkg::CNT_W'(l);
  endfunction

  // bus strobes: one access per request, ack drops the cycle after
  // a held request whose ack already stands is not decoded again
  assign wr = cyc_i & stb_i & we_i & ~s_q.ack;
  assign rd = cyc_i & stb_i & ~we_i & ~s_q.ack;
  assign stop_entry = stop_mode_i & ~s_q.stop_d1;

  // the tick inputs are one-cycle enables from the clock generators;
  // the doubled bus clock is only taken while osc run in stop is set,
  // since without it that clock dies on stop entry and the count would hang
  // R3 R14 clock source for the wakeup count
  assign wake_tick = (s_q.use_bus & s_q.cfg2[swt_pkg::OSCRUN_BIT]) ? bus2x_tick_i : rc_tick_i;
  // R11 wake period
  assign wake_per = pick(s_q.cfg1[swt_pkg::PERSEL_BIT], swt_pkg::WAKE_SHORT,
                         swt_pkg::WAKE_LONG);
  // R12 watchdog period
  assign wdog_per = pick(s_q.cfg1[swt_pkg::PERSEL_BIT], swt_pkg::WDOG_SHORT,
                         swt_pkg::WDOG_LONG);
  // leaving stop or entering wait parks the count at zero
  // R4 R5 R7 counts only in stop with enable; restart on stop entry
  assign wake_clr = stop_entry | ~stop_mode_i | wait_mode_i | ~s_q.wie;
  // watchdog counts only outside stop, restarted by any config one write
  assign wdog_tick = bus4x_tick_i & ~stop_mode_i;
  assign wdog_clr = stop_mode_i | (wr && adr_i == swt_pkg::CFG1_OFF);

  // wakeup count, held at zero whenever it must not run
  swt_period_counter #(.W(swt_pkg::CNT_W)) u_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(wake_clr),
    .tick_i(wake_tick),
    .period_i(wake_per),
    .done_o(wake_done)
  );

  // watchdog timebase shares the period select bit
  swt_period_counter #(.W(swt_pkg::CNT_W)) u_wdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(wdog_clr),
    .tick_i(wdog_tick),
    .period_i(wdog_per),
    .done_o(wdog_done)
  );

  // next state: register writes, latch, status and outputs
  always_comb
  begin
    s_d = s_q;
    // stop edge detect, idle low like the mode input after reset
    s_d.stop_d1 = stop_mode_i;
    // ack one cycle after the request, dropped the cycle after
    s_d.ack = cyc_i & stb_i & ~s_q.ack;
    // read data stands only in the ack cycle
    s_d.rdata = '0;
    // register writes, low byte lane only since every register fits in 8 bits
    // the write lands at the edge that raises ack
    if (wr)
    begin
      unique case (adr_i)
        // port a data latches
        swt_pkg::PORTA_OFF:
        begin
          // R9 no pin behind bit six
          if (sel_i[0])
            s_d.porta = dat_i[5:0];
        end
        // config one: period select and trip level among others
        swt_pkg::CFG1_OFF:
        begin
          if (sel_i[0])
            s_d.cfg1 = dat_i[7:0];
        end
        // config two: oscillator run in stop
        swt_pkg::CFG2_OFF:
        begin
          if (sel_i[0])
            s_d.cfg2 = dat_i[7:0];
        end
        // keyboard enable register holds only the wake enable here
        swt_pkg::KBEN_OFF:
        begin
          if (sel_i[0])
            s_d.wie = dat_i[swt_pkg::WIE_BIT];
        end
        // keyboard status and control holds the shared mask
        swt_pkg::KBSC_OFF:
        begin
          if (sel_i[0])
            s_d.kmask = dat_i[swt_pkg::KMASK_BIT];
        end
        // status: write one to clear; a same-cycle set wins further down
        swt_pkg::STAT_OFF:
        begin
          if (sel_i[0])
            s_d.stat = s_q.stat & ~dat_i[1:0];
        end
        // interrupt mask, same layout as status
        swt_pkg::MASK_OFF:
        begin
          if (sel_i[0])
            s_d.mask = dat_i[1:0];
        end
        // mode: count the doubled bus clock, only honoured with osc run set
        swt_pkg::MODE_OFF:
        begin
          if (sel_i[0])
            s_d.use_bus = dat_i[0];
        end
        // unmapped addresses are acked and ignored
        default: ;
      endcase
    end

    // read mux; reserved bits read as zero
    if (rd)
    begin
      unique case (adr_i)
        // R8 latch visible read-only on bit six
        swt_pkg::PORTA_OFF:
          s_d.rdata = {25'h0, s_q.latch, s_q.porta};
        // config registers read back whole
        swt_pkg::CFG1_OFF:
          s_d.rdata = {24'h0, s_q.cfg1};
        swt_pkg::CFG2_OFF:
          s_d.rdata = {24'h0, s_q.cfg2};
        // enable and mask sit at their keyboard bit positions
        swt_pkg::KBEN_OFF:
          s_d.rdata = {25'h0, s_q.wie, 6'h00};
        swt_pkg::KBSC_OFF:
          s_d.rdata = {30'h0, s_q.kmask, 1'b0};
        // event status and its mask
        swt_pkg::STAT_OFF:
          s_d.rdata = {30'h0, s_q.stat};
        swt_pkg::MASK_OFF:
          s_d.rdata = {30'h0, s_q.mask};
        // clock choice
        swt_pkg::MODE_OFF:
          s_d.rdata = {31'h0, s_q.use_bus};
        // unmapped reads return zero
        default:
          s_d.rdata = '0;
      endcase
    end

    // R16 acknowledge clears; disabled enable holds clear
    if (kbd_ack_i | ~s_d.wie)
    begin
      s_d.latch = 1'b0;
    end
    // the latch only sets in stop, so a late count after exit cannot raise it
    // R15 R1 period end sets the latch, set beats clear
    if (wake_done & s_q.wie & stop_mode_i & ~wait_mode_i)
    begin
      s_d.latch = 1'b1;
    end
    // status events; set wins over write-one-to-clear in the same cycle
    if (wake_done & s_q.wie)
    begin
      s_d.stat[swt_pkg::EV_WAKE] = 1'b1;
    end
    if (wdog_done)
    begin
      s_d.stat[swt_pkg::EV_WDOG] = 1'b1;
    end
    // built from the next latch so the request and the latch rise together
    // R2 R15 shared keyboard vector, gated by the shared mask
    s_d.kirq = s_d.latch & s_d.wie & ~s_d.kmask;
    // R6 exit stop only while unmasked
    s_d.wstop = s_d.kirq & stop_mode_i;
    // R10 oscillator keeps running in stop only when asked
    s_d.oscrun = ~stop_mode_i | s_d.cfg2[swt_pkg::OSCRUN_BIT];
    // one cycle wide; whoever resets the part stretches it if needed
    s_d.wdrst = wdog_done;
    // level interrupt while any unmasked status bit is set
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  // synchronous reset; por_i is sampled together with rst_i
  // R13 power-on clears all; other resets keep trip level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // everything idle, clock source running
      s_q <= '0;
      s_q.oscrun <= 1'b1;
      // config two and port a clear on any reset
      s_q.cfg2 <= swt_pkg::CFG2_RST;
      s_q.porta <= swt_pkg::PORTA_RST;
      // config one keeps only the trip level unless this is power-on
      if (por_i)
        s_q.cfg1 <= swt_pkg::CFG1_RST;
      else
        s_q.cfg1 <= {4'h0, s_q.cfg1[swt_pkg::TRIP_BIT], 3'h0};
    end
    else
      s_q <= s_d;
  end

  // bus answer
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  // keyboard vector request and stop exit
  assign kbd_irq_o = s_q.kirq;
  assign wake_stop_o = s_q.wstop;
  // clock control and watchdog
  assign osc_run_o = s_q.oscrun;
  assign wdog_reset_o = s_q.wdrst;
  // status interrupt
  assign irq_o = s_q.irq;
endmodule // swt_wakeup_timer

// file: sim/swt_assertions.sv
`timescale 1ns/1ps
module swt_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and chip status
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic stop_mode_i,
  input wire logic kbd_ack_i,
  // events
  input wire logic kbd_irq_o,
  input wire logic wake_stop_o,
  input wire logic osc_run_o,
  input wire logic wdog_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus answer and event relations
  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_osc_awake: assert property (!stop_mode_i |=> osc_run_o)
    else $error("clock source off outside stop");
  a_wdog_pulse: assert property (wdog_reset_o |=> !wdog_reset_o)
    else $error("watchdog pulse too long");
  a_wdog_stop: assert property (stop_mode_i [*3] |-> !wdog_reset_o)
    else $error("watchdog fired in stop");
  a_wake_in_stop: assert property (wake_stop_o |-> $past(stop_mode_i))
    else $error("wakeup outside stop");
  a_wake_unmasked: assert property (wake_stop_o |-> kbd_irq_o || $past(kbd_irq_o))
    else $error("wakeup without keyboard request");
  a_ack_clears: assert property (kbd_ack_i && kbd_irq_o |=> ##1 !kbd_irq_o)
    else $error("request kept after acknowledge");
  // main scenarios reached
  c_wake: cover property ($rose(kbd_irq_o));
  c_leave: cover property (wake_stop_o);
  c_wdog: cover property (wdog_reset_o);
endmodule // swt_assertions
bind swt_wakeup_timer swt_assertions u_swt_assertions (.*);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // stimulus and observed signals
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
  logic rc_tick_i = 1'b0, bus2x_tick_i = 1'b0, bus4x_tick_i = 1'b0, kbd_ack_i = 1'b0;
  logic stop_mode_i = 1'b0, wait_mode_i = 1'b0, por_i = 1'b1;
  logic ack_o, kbd_irq_o, wake_stop_o, osc_run_o, wdog_reset_o, irq_o;
  localparam logic [31:0] z = 32'h0000_0000;
  localparam logic [31:0] b6 = 32'h0000_0040;
  int error_cnt = 0, total_checks = 0, n;
  // 8 ns clock
  initial forever #4 clk_i = ~clk_i;
  swt_wakeup_timer u_swt_wakeup_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .rc_tick_i(rc_tick_i),
    .bus2x_tick_i(bus2x_tick_i),
    .bus4x_tick_i(bus4x_tick_i),
    .stop_mode_i(stop_mode_i),
    .wait_mode_i(wait_mode_i),
    .por_i(por_i),
    .kbd_ack_i(kbd_ack_i),
    .kbd_irq_o(kbd_irq_o),
    .wake_stop_o(wake_stop_o),
    .osc_run_o(osc_run_o),
    .wdog_reset_o(wdog_reset_o),
    .irq_o(irq_o)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rst(input logic p);
    por_i <= p;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // bounded wait for keyboard request (s=0) or watchdog (s=1)
  task automatic till(input logic s, output int c);
    c = 0;
    while ((s ? wdog_reset_o : kbd_irq_o) !== 1'b1 && c < 17000)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask
  task automatic t_regs;
    wb(1'b0, swt_pkg::CFG1_OFF, z);
    chk(q, z);
    wb(1'b1, swt_pkg::PORTA_OFF, 32'h0000_007F);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q, 32'h0000_003F);
    wb(1'b0, 8'h20, z);
    chk(q, z);
    wb(1'b1, swt_pkg::CFG1_OFF, 32'h0000_0088);
    rst(1'b0);
    wb(1'b0, swt_pkg::CFG1_OFF, z);
    chk(q, 32'h0000_0008);
    rst(1'b1);
    $display("t_regs done");
  endtask
  task automatic t_wake;
    wb(1'b1, swt_pkg::KBEN_OFF, b6);
    wb(1'b1, swt_pkg::CFG1_OFF, 32'h0000_0080);
    wb(1'b1, swt_pkg::MASK_OFF, 32'h0000_0001);
    rc_tick_i <= 1'b1;
    stop_mode_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    stop_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    stop_mode_i <= 1'b1;
    till(1'b0, n);
    chk(32'(n >= 512 && n <= 518), 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(32'({wake_stop_o, irq_o}), 32'h0000_0003);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q & b6, b6);
    kbd_ack_i <= 1'b1;
    @(posedge clk_i);
    kbd_ack_i <= 1'b0;
    wb(1'b1, swt_pkg::STAT_OFF, 32'h0000_0001);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q & b6, z);
    chk(32'(irq_o), z);
    stop_mode_i <= 1'b0;
    $display("t_wake done");
  endtask
  // wait mode must stay silent with ticks running
  task automatic t_wait;
    wait_mode_i <= 1'b1;
    stop_mode_i <= 1'b1;
    repeat (600) @(posedge clk_i);
    wb(1'b0, swt_pkg::STAT_OFF, z);
    chk(q, z);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q & b6, z);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b0;
    rc_tick_i <= 1'b0;
    $display("t_wait done");
  endtask
  task automatic t_mask;
    wb(1'b1, swt_pkg::CFG2_OFF, 32'h0000_0002);
    wb(1'b1, swt_pkg::MODE_OFF, 32'h0000_0001);
    wb(1'b1, swt_pkg::KBSC_OFF, 32'h0000_0002);
    bus2x_tick_i <= 1'b1;
    stop_mode_i <= 1'b1;
    repeat (600) @(posedge clk_i);
    chk(32'({osc_run_o, kbd_irq_o, wake_stop_o}), 32'h0000_0004);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q & b6, b6);
    wb(1'b1, swt_pkg::KBEN_OFF, z);
    wb(1'b0, swt_pkg::PORTA_OFF, z);
    chk(q & b6, z);
    wb(1'b1, swt_pkg::CFG2_OFF, z);
    repeat (2) @(posedge clk_i);
    chk(32'(osc_run_o), z);
    stop_mode_i <= 1'b0;
    bus2x_tick_i <= 1'b0;
    $display("t_mask done");
  endtask
  task automatic t_wdog;
    bus4x_tick_i <= 1'b1;
    wb(1'b1, swt_pkg::CFG1_OFF, 32'h0000_0080);
    till(1'b1, n);
    chk(32'(n >= 8176 && n <= 8182), 32'h0000_0001);
    wb(1'b0, swt_pkg::STAT_OFF, z);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    bus4x_tick_i <= 1'b0;
    $display("t_wdog done");
  endtask
  // long wake period on the internal rc clock, unmasked
  task automatic t_long;
    wb(1'b1, swt_pkg::KBSC_OFF, z);
    wb(1'b1, swt_pkg::KBEN_OFF, b6);
    wb(1'b1, swt_pkg::CFG1_OFF, z);
    rc_tick_i <= 1'b1;
    stop_mode_i <= 1'b1;
    till(1'b0, n);
    chk(32'(n >= 16384 && n <= 16390), 32'h0000_0001);
    chk(32'(wake_stop_o), 32'h0000_0001);
    stop_mode_i <= 1'b0;
    rc_tick_i <= 1'b0;
    $display("t_long done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst(1'b1);
    t_regs;
    t_wake;
    t_wait;
    t_mask;
    t_wdog;
    t_long;
    end_of_test;
  end
  // hang guard, well beyond the expected run
  initial
  begin
    #400000;
    error_cnt++;
    end_of_test;
  end
endmodule // tb_top
